// [logic/ocd_decode_regs.vh]
/*
 * constants for the opcode decode tail: opcode patterns, select codes,
 * state counts and the control-output encodings. assumes a core clocked
 * at 25 MHz with opcodes delivered one byte at a time by fetch logic.
 */
`ifndef OCD_DECODE_REGS_VH
`define OCD_DECODE_REGS_VH

// -------------------------------------------------------------------------
// opcode patterns
// -------------------------------------------------------------------------
`define OCD_OP_SWAP_DE_HL   8'hEB
`define OCD_OP_SWAP_STACK   8'hE3
`define OCD_OP_LOAD_SP_IMM  8'h31
`define OCD_OP_XOR_MEM      8'hAE
`define OCD_OP_SUB_MEM      8'h96
`define OCD_OP_SUB_IMM      8'hD6
`define OCD_PFX_XOR_REG     5'h15
`define OCD_PFX_SUB_REG     5'h12
`define OCD_PFX_COND_RET    2'h3
`define OCD_LO_COND_RET     3'h0

// -------------------------------------------------------------------------
// register select field
// -------------------------------------------------------------------------
`define OCD_SEL_B    3'h0
`define OCD_SEL_C    3'h1
`define OCD_SEL_D    3'h2
`define OCD_SEL_E    3'h3
`define OCD_SEL_H    3'h4
`define OCD_SEL_L    3'h5
`define OCD_SEL_MEM  3'h6
`define OCD_SEL_A    3'h7

// -------------------------------------------------------------------------
// state counts
// -------------------------------------------------------------------------
`define OCD_ST_SWAP_PAIR   5'h04
`define OCD_ST_SWAP_STACK  5'h12
`define OCD_ST_LOAD_SP     5'h0A
`define OCD_ST_ALU_MEM     5'h07
`define OCD_ST_ALU_REG     5'h04
`define OCD_ST_ALU_IMM     5'h07
`define OCD_ST_COND_SHORT  5'h05
`define OCD_ST_COND_LONG   5'h0B
`define OCD_ST_NONE        5'h00

// -------------------------------------------------------------------------
// operation codes driven to the datapath
// -------------------------------------------------------------------------
`define OCD_ACT_NONE       4'h0
`define OCD_ACT_SWAP_PAIR  4'h1
`define OCD_ACT_SWAP_STACK 4'h2
`define OCD_ACT_LOAD_SP    4'h3
`define OCD_ACT_XOR        4'h4
`define OCD_ACT_SUB        4'h5
`define OCD_ACT_COND_RET   4'h6

// operand source
`define OCD_SRC_REG        2'h0
`define OCD_SRC_MEM        2'h1
`define OCD_SRC_IMM        2'h2
`define OCD_SRC_NONE       2'h3

// condition codes in bits 5:3 of a conditional opcode
`define OCD_CC_NZ  3'h0
`define OCD_CC_Z   3'h1
`define OCD_CC_NC  3'h2
`define OCD_CC_C   3'h3
`define OCD_CC_PO  3'h4
`define OCD_CC_PE  3'h5
`define OCD_CC_P   3'h6
`define OCD_CC_M   3'h7

// operand byte counts
`define OCD_IMM_NONE 2'h0
`define OCD_IMM_ONE  2'h1
`define OCD_IMM_TWO  2'h2

// operand word value before any byte is captured
`define OCD_IMM_CLEAR 16'h0000

`endif

// [logic/ocd_decode.v]
/*
 * opcode decode tail: turns one opcode byte into datapath controls, a
 * state count and an operand-fetch sequence for immediate bytes.
 * assumes fetch presents opcode with opValid for one cycle, presents each
 * operand byte with byteValid, and that flags are stable at opValid.
 */
// Operation
// - EB swaps D/E with H/L, 4 states
// - E3 swaps H/L with stack top, 18
// - 31 loads SP from immediate, 10
// - AE xors memory into A, 7
// - 10101sss xors register into A, 4
// - 10010sss subtracts register from A, 4
// - 96 subtracts memory from A, 7
// - D6 subtracts immediate byte from A, 7
// - select codes B,C,D,E,H,L,M,A = 0..7
// - conditional ops take short or long time
`timescale 1ns/1ns
`include "ocd_decode_regs.vh"

module ocd_decode (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // from fetch
    input  wire        opValid,
    input  wire [7:0]  opcode,
    input  wire        byteValid,
    input  wire [7:0]  operandByte,
    // processor flags
    input  wire        flagZero,
    input  wire        flagCarry,
    input  wire        flagParity,
    input  wire        flagSign,
    // to datapath
    output reg         decodeValid,
    output reg  [3:0]  action,
    output reg  [1:0]  operandSource,
    output reg  [2:0]  sourceSelectField,
    output reg  [4:0]  stateCount,
    output reg         conditionTaken,
    output reg         unsupported,
    output reg  [15:0] immediateValue,
    output reg         immediateDone,
    output reg         pcAdvance,
    output reg         busy
);

    // ---------------------------------------------------------------------
    // condition evaluation
    // ---------------------------------------------------------------------
    function condMet;
        input [2:0] cc;
        input       z, cy, p, s;
        begin
            case (cc)
                `OCD_CC_NZ: condMet = ~z;
                `OCD_CC_Z:  condMet = z;
                `OCD_CC_NC: condMet = ~cy;
                `OCD_CC_C:  condMet = cy;
                `OCD_CC_PO: condMet = ~p;
                `OCD_CC_PE: condMet = p;
                `OCD_CC_P:  condMet = ~s;
                default:    condMet = s;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------------
    // register-select decode
    // ---------------------------------------------------------------------
    // memory operand costs a bus cycle, hence the longer state count
    function selIsMem;
        input [2:0] sel;
        begin
            selIsMem = (sel == `OCD_SEL_MEM);
        end
    endfunction

    // ---------------------------------------------------------------------
    // combinational decode
    // ---------------------------------------------------------------------
    reg [3:0] next_action;
    reg [1:0] next_source;
    reg [4:0] next_states;
    reg [1:0] next_immBytes;
    reg       next_taken;
    reg       next_unsupported;

    always @* begin
        next_action      = `OCD_ACT_NONE;
        next_source      = `OCD_SRC_NONE;
        next_states      = `OCD_ST_NONE;
        next_immBytes    = `OCD_IMM_NONE;
        next_taken       = 1'b0;
        next_unsupported = 1'b0;
        if (opcode == `OCD_OP_SWAP_DE_HL) begin
            next_action = `OCD_ACT_SWAP_PAIR;
            next_states = `OCD_ST_SWAP_PAIR;
        end else if (opcode == `OCD_OP_SWAP_STACK) begin
            // SP itself is left alone; datapath reads and writes at SP
            next_action = `OCD_ACT_SWAP_STACK;
            next_states = `OCD_ST_SWAP_STACK;
        end else if (opcode == `OCD_OP_LOAD_SP_IMM) begin
            next_action   = `OCD_ACT_LOAD_SP;
            next_source   = `OCD_SRC_IMM;
            next_immBytes = `OCD_IMM_TWO;
            next_states   = `OCD_ST_LOAD_SP;
        end else if (opcode == `OCD_OP_SUB_IMM) begin
            next_action   = `OCD_ACT_SUB;
            next_source   = `OCD_SRC_IMM;
            next_immBytes = `OCD_IMM_ONE;
            next_states   = `OCD_ST_ALU_IMM;
        end else if (opcode[7:3] == `OCD_PFX_XOR_REG) begin
            next_action = `OCD_ACT_XOR;
            if (selIsMem(opcode[2:0])) begin
                next_source = `OCD_SRC_MEM;
                next_states = `OCD_ST_ALU_MEM;
            end else begin
                next_source = `OCD_SRC_REG;
                next_states = `OCD_ST_ALU_REG;
            end
        end else if (opcode[7:3] == `OCD_PFX_SUB_REG) begin
            next_action = `OCD_ACT_SUB;
            if (selIsMem(opcode[2:0])) begin
                next_source = `OCD_SRC_MEM;
                next_states = `OCD_ST_ALU_MEM;
            end else begin
                next_source = `OCD_SRC_REG;
                next_states = `OCD_ST_ALU_REG;
            end
        end else if (opcode[7:6] == `OCD_PFX_COND_RET && opcode[2:0] == `OCD_LO_COND_RET) begin
            // conditional return: long form only when the action happens
            next_action = `OCD_ACT_COND_RET;
            next_taken  = condMet(opcode[5:3], flagZero, flagCarry, flagParity, flagSign);
            next_states = next_taken ? `OCD_ST_COND_LONG : `OCD_ST_COND_SHORT;
        end else begin
            next_unsupported = 1'b1;
        end
    end

    // ---------------------------------------------------------------------
    // operand fetch sequencer
    // ---------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_LOW  = 2'b01;
    localparam [1:0] ST_HIGH = 2'b10;

    reg [1:0] state;
    reg [1:0] pendBytes;

    always @(posedge clk) begin
        if (rst) begin
            state             <= ST_IDLE;
            pendBytes         <= `OCD_IMM_NONE;
            decodeValid       <= 1'b0;
            action            <= `OCD_ACT_NONE;
            operandSource     <= `OCD_SRC_NONE;
            sourceSelectField <= `OCD_SEL_B;
            stateCount        <= `OCD_ST_NONE;
            conditionTaken    <= 1'b0;
            unsupported       <= 1'b0;
            immediateValue    <= `OCD_IMM_CLEAR;
            immediateDone     <= 1'b0;
            pcAdvance         <= 1'b0;
            busy              <= 1'b0;
        end else begin
            decodeValid   <= 1'b0;
            immediateDone <= 1'b0;
            pcAdvance     <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // opcodes arriving while operands are pending are ignored
                    if (opValid) begin
                        decodeValid       <= 1'b1;
                        action            <= next_action;
                        operandSource     <= next_source;
                        sourceSelectField <= opcode[2:0];
                        stateCount        <= next_states;
                        conditionTaken    <= next_taken;
                        unsupported       <= next_unsupported;
                        immediateValue    <= `OCD_IMM_CLEAR;
                        pendBytes         <= next_immBytes;
                        // pc steps past the opcode; each operand steps it again
                        pcAdvance         <= 1'b1;
                        if (next_immBytes != `OCD_IMM_NONE) begin
                            state <= ST_LOW;
                            busy  <= 1'b1;
                        end
                    end
                end
                ST_LOW: begin
                    if (byteValid) begin
                        immediateValue[7:0] <= operandByte;
                        pcAdvance           <= 1'b1;
                        // single-byte operand ends here, a word waits for its high byte
                        if (pendBytes == `OCD_IMM_TWO) begin
                            state <= ST_HIGH;
                        end else begin
                            state         <= ST_IDLE;
                            busy          <= 1'b0;
                            immediateDone <= 1'b1;
                        end
                    end
                end
                ST_HIGH: begin
                    if (byteValid) begin
                        immediateValue[15:8] <= operandByte;
                        pcAdvance            <= 1'b1;
                        state                <= ST_IDLE;
                        busy                 <= 1'b0;
                        immediateDone        <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

endmodule // ocd_decode

// [test/ocd_decode_properties.sv]
/* checker for ocd_decode: opcode-to-control relations and operand stepping.
   assumes one clock, sync active-high reset, and sees only decoder ports. */
`timescale 1ns/1ns
module ocd_decode_properties (
    // clock and reset
    input wire       clk,
    input wire       rst,
    // fetch side
    input wire       opValid,
    input wire [7:0] opcode,
    input wire       byteValid,
    // processor flags
    input wire       flagZero,
    input wire       flagCarry,
    input wire       flagParity,
    input wire       flagSign,
    // datapath side
    input wire       decodeValid,
    input wire [3:0] action,
    input wire [1:0] operandSource,
    input wire [2:0] sourceSelectField,
    input wire [4:0] stateCount,
    input wire       conditionTaken,
    input wire       pcAdvance,
    input wire       busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire take = opValid && !busy;
    // condition from bits 5:4 picking the flag, bit 3 its polarity
    wire condFlag = (opcode[5:4] == 2'h0) ? flagZero : (opcode[5:4] == 2'h1) ? flagCarry :
                    (opcode[5:4] == 2'h2) ? flagParity : flagSign;
    wire condNow = opcode[3] ? condFlag : !condFlag;
    AST_SWAP_PAIR: assert property (take && opcode == 8'hEB |=> decodeValid && action == 4'h1 && stateCount == 5'h04)
        else $error("swap pair decode wrong");
    AST_SWAP_STACK: assert property (take && opcode == 8'hE3 |=> action == 4'h2 && stateCount == 5'h12)
        else $error("stack swap decode wrong");
    AST_LOAD_SP: assert property (take && opcode == 8'h31 |=> action == 4'h3 && operandSource == 2'h2 && busy)
        else $error("load sp decode wrong");
    AST_MEM_ALU: assert property (take && (opcode == 8'hAE || opcode == 8'h96) |=> operandSource == 2'h1
        && stateCount == 5'h07 && action == ($past(opcode[3]) ? 4'h4 : 4'h5)) else $error("memory alu decode wrong");
    AST_XOR_REG: assert property (take && opcode[7:3] == 5'h15 && opcode[2:0] != 3'h6 |=> action == 4'h4
        && operandSource == 2'h0 && stateCount == 5'h04) else $error("xor register decode wrong");
    AST_SUB_REG: assert property (take && opcode[7:3] == 5'h12 && opcode[2:0] != 3'h6 |=> action == 4'h5
        && operandSource == 2'h0 && stateCount == 5'h04) else $error("sub register decode wrong");
    AST_SUB_IMM: assert property (take && opcode == 8'hD6 |=> action == 4'h5 && operandSource == 2'h2
        && stateCount == 5'h07 && busy) else $error("sub immediate decode wrong");
    AST_SELECT: assert property (take && (opcode[7:3] == 5'h15 || opcode[7:3] == 5'h12) |=>
        sourceSelectField == $past(opcode[2:0])) else $error("select field wrong");
    AST_COND_TIME: assert property (take && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h0 |=>
        conditionTaken == $past(condNow) && stateCount == ($past(condNow) ? 5'h0B : 5'h05))
        else $error("conditional timing wrong");
    AST_PC_STEP: assert property ((take || (busy && byteValid)) |=> pcAdvance)
        else $error("pc step missing");
endmodule // ocd_decode_properties

bind ocd_decode ocd_decode_properties i_ocd_decode_properties (.*);

// [test/ocd_fetch_model.sv]
/* fetch-side model: hands operand bytes to the decoder while it waits.
   assumes the decoder takes a byte on each rising edge that sees byteValid. */
`timescale 1ns/1ns
module ocd_fetch_model (
    // clock and control
    input  wire        clk,
    input  wire        busy,
    input  wire        stall,
    input  wire [15:0] word,
    // to decoder
    output reg         byteValid,
    output reg  [7:0]  operandByte
);
    reg idx;
    initial begin
        byteValid = 1'b0;
        operandByte = 8'h00;
        idx = 1'b0;
    end
    // low byte first; an idle line shows the inverse so stale data never matches
    always @(negedge clk) begin
        if (byteValid)
            idx = ~idx;
        if (!busy)
            idx = 1'b0;
        byteValid = busy && !stall;
        operandByte = byteValid ? (idx ? word[15:8] : word[7:0]) : ~operandByte;
    end
endmodule // ocd_fetch_model

// [test/tb.sv]
/* testbench for ocd_decode: table of opcodes, conditional timing, operands.
   assumes the fetch model supplies operand bytes while the decoder is busy. */
`timescale 1ns/1ns
module tb;
    reg         clk, rst, opValid, flagZero, flagCarry, flagParity, flagSign, stall;
    reg  [7:0]  opcode;
    reg  [15:0] word;
    wire        byteValid, decodeValid, conditionTaken, unsupported, immediateDone, pcAdvance, busy;
    wire [7:0]  operandByte;
    wire [3:0]  action;
    wire [1:0]  operandSource;
    wire [2:0]  sourceSelectField;
    wire [4:0]  stateCount;
    wire [15:0] immediateValue;
    integer     n_mismatch = 0, cmp_count = 0, i, f, k;
    reg         taken;

    ocd_decode i_ocd_decode (.*);
    ocd_fetch_model i_ocd_fetch_model (.*);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task issue(input [7:0] op);
        begin
            @(negedge clk) opValid = 1'b1;
            opcode = op;
            @(negedge clk) opValid = 1'b0;
            chk(decodeValid, 16'h1);
            chk(pcAdvance, 16'h1);
        end
    endtask
    task t_fixed(input [7:0] op, input [3:0] act, input [1:0] src, input [4:0] st);
        begin
            issue(op);
            chk(action, act);
            chk(operandSource, src);
            chk(stateCount, st);
            chk(unsupported, 16'h0);
        end
    endtask
    // operand fetch with a stalled far side and a refused opcode meanwhile
    task t_imm(input [7:0] op, input [15:0] w, input [15:0] exp);
        begin
            @(posedge clk) stall <= 1'b1;
            word = w;
            issue(op);
            @(negedge clk) opValid = 1'b1;
            opcode = 8'hEB;
            @(negedge clk) opValid = 1'b0;
            chk(decodeValid, 16'h0);
            @(posedge clk) stall <= 1'b0;
            for (k = 0; k < 8 && immediateDone !== 1'b1; k = k + 1)
                @(negedge clk);
            chk(immediateDone, 16'h1);
            chk(immediateValue, exp);
            chk(action, (op == 8'hD6) ? 16'h5 : 16'h3);
            @(negedge clk) chk(busy, 16'h0);
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        #100000 n_mismatch = n_mismatch + 1;
        test_done;
    end

    initial begin
        {rst, opValid, flagZero, flagCarry, flagParity, flagSign, stall} = 7'h40;
        opcode = 8'h00;
        word = 16'h0000;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(operandSource, 16'h3);
        t_fixed(8'hEB, 4'h1, 2'h3, 5'h04);
        t_fixed(8'hE3, 4'h2, 2'h3, 5'h12);
        t_fixed(8'hAE, 4'h4, 2'h1, 5'h07);
        t_fixed(8'h96, 4'h5, 2'h1, 5'h07);
        for (i = 0; i < 8; i = i + 1) begin
            t_fixed({5'h15, i[2:0]}, 4'h4, (i == 6) ? 2'h1 : 2'h0, (i == 6) ? 5'h07 : 5'h04);
            chk(sourceSelectField, i[2:0]);
            t_fixed({5'h12, i[2:0]}, 4'h5, (i == 6) ? 2'h1 : 2'h0, (i == 6) ? 5'h07 : 5'h04);
            chk(sourceSelectField, i[2:0]);
        end
        for (i = 0; i < 16; i = i + 1) begin
            f = i % 2;
            {flagZero, flagCarry, flagParity, flagSign} = f ? 4'hF : 4'h0;
            taken = i[1] ? f[0] : !f[0];
            issue({2'h3, i[3:1], 3'h0});
            chk(conditionTaken, taken);
            chk(stateCount, taken ? 16'hB : 16'h5);
        end
        // an opcode outside this decode set is flagged and does nothing
        issue(8'hDE);
        chk(unsupported, 16'h1);
        chk(action, 16'h0);
        chk(stateCount, 16'h0);
        t_imm(8'h31, 16'hA55C, 16'hA55C);
        t_imm(8'hD6, 16'h3C96, 16'h0096);
        test_done;
    end
endmodule // tb
